/* File: rtl/rtcsy_core.sv */
// rtc support: prescaler with rate trim, interrupt flags, output events, access crossing
// assumes a counter core on clk_in that supplies hit pulses and the live count/calendar,
// and takes the synchronised commands and count ticks from this block
//
// Functional notes
// - trim adds or skips one count per 1024
// - magnitude picks trimmed periods out of 976
// - sign chooses faster (add) or slower (skip)
// - trim also moves periodic tap event spacing
// - five sources, each with its own flag
// - enable-set and enable-clear ones act, zeros ignored
// - request when flag set and source enabled
// - request holds until clear, disable or reset
// - one shared request line, flags identify cause
// - request combinational from flags, but flags set only on clk_in edges
// - events for wrap, taps, match, alarm
// - each event only while its enable is one
// - keeps running while slow clock and clk_in both run
// - pending bit set at once, cleared on completion
// - completion sets the transfer-done flag
// - access during pending is stalled, then completes
// - soft reset and enable writes are synchronised
// - value, limit, match, alarm, mask, trim writes synchronised
// - count and calendar reads are synchronised
// - tap event on rise of prescaler bit n+2
// - soft reset clears config, enables, flags and prescaler, but sets transfer-done
`timescale 1ns/1ps
`include "rtcsy_defines.svh"
module rtcsy_core (
  // clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            arst_n_in,
  // slow count clock pin
  input  wire logic                            slow_count_clock_in,
  // synchronised access requests
  input  wire logic                            req_valid_in,
  input  wire rtcsy_pkg::rtcsy_req_t           req_in,
  output logic                                 req_ready_out,
  output logic                                 xfer_pending_bit_out,
  // read results
  output logic                                 rd_valid_out,
  output logic [31:0]                          rd_data_out,
  // unsynchronised register strobes
  input  wire logic [`RTCSY_IRQ_W-1:0]         irq_enable_set_reg_in,
  input  wire logic [`RTCSY_IRQ_W-1:0]         irq_enable_clear_reg_in,
  input  wire logic [`RTCSY_IRQ_W-1:0]         irq_flag_clear_in,
  input  wire logic                            event_out_enable_wr_in,
  input  wire logic [`RTCSY_EV_W-1:0]          event_out_enable_data_in,
  // register views
  output logic [`RTCSY_IRQ_W-1:0]              irq_enable_out,
  output logic [`RTCSY_IRQ_W-1:0]              irq_flag_reg_out,
  output logic [`RTCSY_EV_W-1:0]               event_out_enable_reg_out,
  output logic [7:0]                           rate_trim_reg_out,
  output logic                                 enable_out,
  output logic [`RTCSY_CTRL_PRESC_W-1:0]       prescaler_out,
  // interrupt
  output logic                                 irq_out,
  // counter core side
  input  wire rtcsy_pkg::rtcsy_hit_t           hit_in,
  input  wire logic [31:0]                     count_in,
  input  wire logic [31:0]                     calendar_in,
  output rtcsy_pkg::rtcsy_cmd_t                core_cmd_out,
  output logic                                 count_tick_out,
  // event network
  output logic                                 wrap_event_out,
  output logic [1:0]                           match_event_out,
  output logic                                 alarm_event_out,
  output logic [`RTCSY_EV_TAPS-1:0]            tap_n_event_out
);

  // slow clock edge
  logic slow_rise;

  rtcsy_slow_edge u_slow_edge (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .slow_in   (slow_count_clock_in),
    .rise_out  (slow_rise)
  );

  // crossing state
  rtcsy_pkg::rtcsy_xs_t  xs_q;
  rtcsy_pkg::rtcsy_req_t hold_q;
  logic                  accept;
  logic                  ack;
  logic                  soft_rst;

  // configuration: control and trim change on the slow edge, enables and flags on any edge
  logic                            enable_q;
  logic [`RTCSY_CTRL_PRESC_W-1:0]  presc_sel_q;
  logic [7:0]                      trim_q;
  logic [`RTCSY_IRQ_W-1:0]         irq_en_q;
  logic [`RTCSY_IRQ_W-1:0]         irq_flag_q;
  logic [`RTCSY_EV_W-1:0]          ev_en_q;

  // prescaler and trim
  logic [`RTCSY_PRESC_W-1:0]       presc_q;
  logic [`RTCSY_PRESC_W-1:0]       presc_d;
  logic [`RTCSY_TRIM_PERIOD_W-1:0] trim_cyc_q;
  logic [`RTCSY_TRIM_SPAN_W-1:0]   trim_span_q;
  logic                            trim_end;
  logic                            trim_apply;
  logic [`RTCSY_PRESC_W-1:0]       presc_rise;
  logic                            running;

  // a request is taken only while nothing is pending; the master sees
  // req_ready_out low and must hold its request, which stalls it
  assign req_ready_out        = (xs_q == rtcsy_pkg::RTCSY_XS_IDLE);
  assign accept               = req_valid_in & req_ready_out;
  assign xfer_pending_bit_out = (xs_q != rtcsy_pkg::RTCSY_XS_IDLE);

  // slow side captures the held request on its next edge and acknowledges
  assign ack      = (xs_q == rtcsy_pkg::RTCSY_XS_WAIT) & slow_rise;
  assign soft_rst = ack & (hold_q.sel == rtcsy_pkg::RTCSY_SEL_CTRL)
                        & hold_q.data[`RTCSY_CTRL_SOFT_RESET];

  // handshake: data stays frozen in hold_q until ack
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      xs_q <= rtcsy_pkg::RTCSY_XS_IDLE;
    end else begin
      case (xs_q)
        rtcsy_pkg::RTCSY_XS_IDLE: begin
          if (accept) begin
            xs_q <= rtcsy_pkg::RTCSY_XS_WAIT;
          end
        end
        rtcsy_pkg::RTCSY_XS_WAIT: begin
          if (ack) begin
            xs_q <= rtcsy_pkg::RTCSY_XS_IDLE;
          end
        end
        default: begin
          xs_q <= rtcsy_pkg::RTCSY_XS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_q <= '0;
    end else if (accept) begin
      hold_q <= req_in;
    end
  end

  // control word: enable and prescaler take effect only on the slow edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      enable_q    <= 1'b0;
      presc_sel_q <= `RTCSY_RST_PRESC;
    end else if (soft_rst) begin
      enable_q    <= 1'b0;
      presc_sel_q <= `RTCSY_RST_PRESC;
    end else if (ack && hold_q.sel == rtcsy_pkg::RTCSY_SEL_CTRL) begin
      enable_q    <= hold_q.data[`RTCSY_CTRL_ENABLE];
      presc_sel_q <= hold_q.data[`RTCSY_CTRL_PRESC_LSB +: `RTCSY_CTRL_PRESC_W];
    end
  end

  // rate trim word
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trim_q <= `RTCSY_RST_TRIM;
    end else if (soft_rst) begin
      trim_q <= `RTCSY_RST_TRIM;
    end else if (ack && hold_q.sel == rtcsy_pkg::RTCSY_SEL_RATE_TRIM) begin
      trim_q <= hold_q.data[7:0];
    end
  end

  // synchronised writes reach the counter core as one pulse the cycle after the ack
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_cmd_out <= '0;
    end else begin
      core_cmd_out.valid <= ack & (hold_q.sel != rtcsy_pkg::RTCSY_SEL_RD_COUNT)
                                & (hold_q.sel != rtcsy_pkg::RTCSY_SEL_RD_CAL);
      if (ack) begin
        core_cmd_out.sel  <= hold_q.sel;
        core_cmd_out.data <= hold_q.data;
      end
    end
  end

  // reads sample the live value on the slow edge, so it is stable when taken
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 32'h0000_0000;
    end else begin
      rd_valid_out <= 1'b0;
      if (ack && hold_q.sel == rtcsy_pkg::RTCSY_SEL_RD_COUNT) begin
        rd_valid_out <= 1'b1;
        rd_data_out  <= count_in;
      end else if (ack && hold_q.sel == rtcsy_pkg::RTCSY_SEL_RD_CAL) begin
        rd_valid_out <= 1'b1;
        rd_data_out  <= calendar_in;
      end
    end
  end

  // prescaler steps on slow edges sampled by clk_in, so it keeps going only in sleep states
  // where clk_in and the slow clock both run; trim steps it by two (add) or zero (skip)
  assign running    = enable_q & slow_rise;
  assign trim_end   = (trim_cyc_q == `RTCSY_TRIM_PERIOD_W'(`RTCSY_TRIM_PERIOD - 1));
  assign trim_apply = trim_end
                    & (trim_span_q < `RTCSY_TRIM_SPAN_W'(trim_q[`RTCSY_TRIM_MAG_W-1:0]));

  always_comb begin
    presc_d = presc_q;
    if (running) begin
      if (!trim_apply) begin
        presc_d = presc_q + `RTCSY_PRESC_W'(1);
      end else if (!trim_q[`RTCSY_TRIM_SIGN]) begin
        presc_d = presc_q + `RTCSY_PRESC_W'(2);
      end else begin
        presc_d = presc_q;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      presc_q <= '0;
    end else if (soft_rst) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  // trim cycle counters: 1024 slow edges per period, 976 periods per span
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trim_cyc_q  <= '0;
      trim_span_q <= '0;
    end else if (soft_rst) begin
      trim_cyc_q  <= '0;
      trim_span_q <= '0;
    end else if (running) begin
      trim_cyc_q <= trim_cyc_q + `RTCSY_TRIM_PERIOD_W'(1);
      if (trim_end) begin
        if (trim_span_q == `RTCSY_TRIM_SPAN_W'(`RTCSY_TRIM_SPAN - 1)) begin
          trim_span_q <= '0;
        end else begin
          trim_span_q <= trim_span_q + `RTCSY_TRIM_SPAN_W'(1);
        end
      end
    end
  end

  // rising bits of the prescaler; a trimmed step moves these edges too
  assign presc_rise = ~presc_q & presc_d;

  // count tick: every slow edge at setting zero, none above 10, else rise of bit setting-1
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_tick_out <= 1'b0;
    end else if (presc_sel_q == `RTCSY_CTRL_PRESC_W'(0)) begin
      count_tick_out <= running;
    end else if (presc_sel_q > `RTCSY_CTRL_PRESC_W'(`RTCSY_PRESC_W)) begin
      count_tick_out <= 1'b0;
    end else begin
      count_tick_out <= presc_rise[presc_sel_q - `RTCSY_CTRL_PRESC_W'(1)];
    end
  end

  // periodic taps: bits 2..9 of the prescaler, silent at setting zero
  genvar g;
  generate
    for (g = 0; g < `RTCSY_EV_TAPS; g = g + 1) begin : g_tap
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          tap_n_event_out[g] <= 1'b0;
        end else begin
          tap_n_event_out[g] <= presc_rise[g + `RTCSY_EV_TAP_BASE]
                              & ev_en_q[`RTCSY_EV_TAP_LSB + g]
                              & (presc_sel_q != `RTCSY_CTRL_PRESC_W'(0));
        end
      end
    end
  endgenerate

  // event output enables: plain write, ones enable and zeros disable
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ev_en_q <= `RTCSY_RST_EV_EN;
    end else if (soft_rst) begin
      ev_en_q <= `RTCSY_RST_EV_EN;
    end else if (event_out_enable_wr_in) begin
      ev_en_q <= event_out_enable_data_in;
    end
  end

  // events follow the same hits that set the flags
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wrap_event_out  <= 1'b0;
      match_event_out <= 2'b00;
      alarm_event_out <= 1'b0;
    end else begin
      wrap_event_out     <= hit_in.wrap & ev_en_q[`RTCSY_EV_WRAP];
      match_event_out[0] <= hit_in.match[0] & ev_en_q[`RTCSY_EV_MATCH0];
      match_event_out[1] <= hit_in.match[1] & ev_en_q[`RTCSY_EV_MATCH1];
      alarm_event_out    <= hit_in.alarm & ev_en_q[`RTCSY_EV_ALARM];
    end
  end

  // interrupt enables
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_en_q <= `RTCSY_RST_IRQ_EN;
    end else if (soft_rst) begin
      irq_en_q <= `RTCSY_RST_IRQ_EN;
    end else begin
      irq_en_q <= (irq_en_q | irq_enable_set_reg_in) & ~irq_enable_clear_reg_in;
    end
  end

  // interrupt flags: a hit in the clearing cycle wins over the clear
  logic [`RTCSY_IRQ_W-1:0] irq_set;

  always_comb begin
    irq_set                         = '0;
    irq_set[`RTCSY_IRQ_WRAP]        = hit_in.wrap;
    irq_set[`RTCSY_IRQ_MATCH0]      = hit_in.match[0];
    irq_set[`RTCSY_IRQ_MATCH1]      = hit_in.match[1];
    irq_set[`RTCSY_IRQ_ALARM]       = hit_in.alarm;
    irq_set[`RTCSY_IRQ_XFER_DONE]   = ack;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_flag_q <= `RTCSY_RST_IRQ_FLAG;
    end else if (soft_rst) begin
      irq_flag_q <= `RTCSY_RST_IRQ_FLAG | irq_set;
    end else begin
      irq_flag_q <= (irq_flag_q & ~irq_flag_clear_in) | irq_set;
    end
  end

  // one line for all sources; no register after the flags, but a hit sets its
  // flag only on a clk_in edge, so a sleeping system needs the bus clock
  assign irq_out = |(irq_flag_q & irq_en_q);

  // register views
  assign irq_enable_out           = irq_en_q;
  assign irq_flag_reg_out         = irq_flag_q;
  assign event_out_enable_reg_out = ev_en_q;
  assign rate_trim_reg_out        = trim_q;
  assign enable_out               = enable_q;
  assign prescaler_out            = presc_sel_q;

endmodule : rtcsy_core

/* File: shared/rtcsy_defines.svh */
// constants for the rate-trim, interrupt, event and crossing logic of the rtc support block
// assumes it is included by bare name after the package has been compiled
`ifndef RTCSY_DEFINES_SVH
`define RTCSY_DEFINES_SVH

// clock and periods
`define RTCSY_CLK_HZ          25000000
`define RTCSY_TRIM_PERIOD     1024
`define RTCSY_TRIM_SPAN       976
`define RTCSY_TRIM_PERIOD_W   10
`define RTCSY_TRIM_SPAN_W     10
`define RTCSY_PRESC_W         10

// control word written through the synchronised path
`define RTCSY_CTRL_SOFT_RESET 0
`define RTCSY_CTRL_ENABLE     1
`define RTCSY_CTRL_PRESC_LSB  8
`define RTCSY_CTRL_PRESC_W    4

// rate trim word
`define RTCSY_TRIM_SIGN       7
`define RTCSY_TRIM_MAG_W      7

// interrupt flag positions
`define RTCSY_IRQ_W           5
`define RTCSY_IRQ_WRAP        0
`define RTCSY_IRQ_MATCH0      1
`define RTCSY_IRQ_MATCH1      2
`define RTCSY_IRQ_ALARM       3
`define RTCSY_IRQ_XFER_DONE   4

// event output enable positions
`define RTCSY_EV_W            12
`define RTCSY_EV_TAP_LSB      0
`define RTCSY_EV_TAPS         8
`define RTCSY_EV_TAP_BASE     2
`define RTCSY_EV_MATCH0       8
`define RTCSY_EV_MATCH1       9
`define RTCSY_EV_ALARM        10
`define RTCSY_EV_WRAP         11

// reset values
`define RTCSY_RST_IRQ_EN      5'h00
`define RTCSY_RST_IRQ_FLAG    5'h00
`define RTCSY_RST_EV_EN       12'h000
`define RTCSY_RST_TRIM        8'h00
`define RTCSY_RST_PRESC       4'h0

`endif

/* File: shared/rtcsy_pkg.sv */
// types shared by the rtc support block
// assumes nothing beyond a systemverilog compiler
package rtcsy_pkg;

  // target of a synchronised access
  typedef enum logic [3:0] {
    RTCSY_SEL_CTRL      = 4'h0,
    RTCSY_SEL_COUNT     = 4'h1,
    RTCSY_SEL_CALENDAR  = 4'h2,
    RTCSY_SEL_WRAP_LIM  = 4'h3,
    RTCSY_SEL_MATCH0    = 4'h4,
    RTCSY_SEL_MATCH1    = 4'h5,
    RTCSY_SEL_ALARM     = 4'h6,
    RTCSY_SEL_ALARM_MSK = 4'h7,
    RTCSY_SEL_RATE_TRIM = 4'h8,
    RTCSY_SEL_RD_COUNT  = 4'h9,
    RTCSY_SEL_RD_CAL    = 4'hA
  } rtcsy_sel_t;

  // one access request, and the command handed to the counter core
  typedef struct packed {
    rtcsy_sel_t  sel;
    logic [31:0] data;
  } rtcsy_req_t;

  typedef struct packed {
    logic        valid;
    rtcsy_sel_t  sel;
    logic [31:0] data;
  } rtcsy_cmd_t;

  // hit pulses from the counter core
  typedef struct packed {
    logic       wrap;
    logic [1:0] match;
    logic       alarm;
  } rtcsy_hit_t;

  // crossing state: gray order idle -> wait
  typedef enum logic [1:0] {
    RTCSY_XS_IDLE = 2'b00,
    RTCSY_XS_WAIT = 2'b01
  } rtcsy_xs_t;

endpackage : rtcsy_pkg

/* File: rtl/rtcsy_slow_edge.sv */
// two-flop synchroniser and rising-edge pulse for the slow count clock pin
// assumes clk_in is much faster than the slow clock (at least 3 samples per phase)
`timescale 1ns/1ps
module rtcsy_slow_edge (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // pin
  input  wire logic slow_in,
  // result
  output logic      rise_out
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // only sync_q reads the first stage
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= slow_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise_out = sync_q & ~prev_q;

endmodule : rtcsy_slow_edge

/* File: tb/rtcsy_core_checker.sv */
// port assertions for the rtc support block
// assumes one clk_in domain reset by arst_n_in
`timescale 1ns/1ps
`include "rtcsy_defines.svh"
module rtcsy_core_checker (
  // clock and reset
  input wire logic                        clk_in,
  input wire logic                        arst_n_in,
  // crossing
  input wire logic                        req_valid_in,
  input wire logic                        req_ready_out,
  input wire logic                        xfer_pending_bit_out,
  // interrupts
  input wire logic [`RTCSY_IRQ_W-1:0]     irq_enable_set_reg_in,
  input wire logic [`RTCSY_IRQ_W-1:0]     irq_enable_clear_reg_in,
  input wire logic [`RTCSY_IRQ_W-1:0]     irq_flag_clear_in,
  input wire logic [`RTCSY_IRQ_W-1:0]     irq_enable_out,
  input wire logic [`RTCSY_IRQ_W-1:0]     irq_flag_reg_out,
  input wire logic                        irq_out,
  // events and prescaler
  input wire rtcsy_pkg::rtcsy_hit_t       hit_in,
  input wire logic [`RTCSY_EV_W-1:0]      event_out_enable_reg_out,
  input wire logic [`RTCSY_CTRL_PRESC_W-1:0] prescaler_out,
  input wire logic                        wrap_event_out,
  input wire logic                        alarm_event_out,
  input wire logic [`RTCSY_EV_TAPS-1:0]   tap_n_event_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_irq_level: assert property (irq_out == |(irq_flag_reg_out & irq_enable_out))
    else $error("irq line differs from flags and enables");
  a_enable_clear: assert property (|irq_enable_clear_reg_in |=>
    (irq_enable_out & $past(irq_enable_clear_reg_in)) == '0)
    else $error("enable clear ignored");
  a_enable_set: assert property (!xfer_pending_bit_out && |irq_enable_set_reg_in
    && irq_enable_clear_reg_in == '0 |=> (irq_enable_out & $past(irq_enable_set_reg_in))
    == $past(irq_enable_set_reg_in)) else $error("enable set ignored");
  a_flag_hold: assert property (irq_flag_reg_out[0] && !irq_flag_clear_in[0]
    && !xfer_pending_bit_out |=> irq_flag_reg_out[0]) else $error("wrap flag lost");
  a_flag_hit: assert property (hit_in.wrap && !xfer_pending_bit_out |=>
    irq_flag_reg_out[`RTCSY_IRQ_WRAP]) else $error("wrap hit not flagged");
  a_flag_clear: assert property (irq_flag_clear_in[3] && !hit_in.alarm |=>
    !irq_flag_reg_out[`RTCSY_IRQ_ALARM]) else $error("alarm flag not cleared");
  a_event_gate: assert property (hit_in.alarm && event_out_enable_reg_out[10] |=>
    alarm_event_out) else $error("alarm event missing");
  a_event_off: assert property (!event_out_enable_reg_out[11] |=> !wrap_event_out)
    else $error("wrap event while disabled");
  a_pend_set: assert property (req_valid_in && req_ready_out |=>
    xfer_pending_bit_out && !req_ready_out) else $error("pending not raised");
  a_pend_bound: assert property ($rose(xfer_pending_bit_out) |->
    ##[1:40] !xfer_pending_bit_out) else $error("crossing never acknowledged");
  a_done_flag: assert property ($fell(xfer_pending_bit_out) |-> irq_flag_reg_out[4])
    else $error("transfer done flag missing");
  a_stall_hold: assert property ($fell(xfer_pending_bit_out) && req_valid_in |->
    req_ready_out ##1 xfer_pending_bit_out) else $error("stalled request not taken");
  a_tap_quiet: assert property (prescaler_out == '0 && $past(prescaler_out) == '0
    && $past(prescaler_out, 2) == '0 |-> tap_n_event_out == '0)
    else $error("tap event at setting zero");
endmodule : rtcsy_core_checker

bind rtcsy_core rtcsy_core_checker u_rtcsy_core_checker (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .xfer_pending_bit_out(xfer_pending_bit_out),
  .irq_enable_set_reg_in(irq_enable_set_reg_in),
  .irq_enable_clear_reg_in(irq_enable_clear_reg_in), .irq_flag_clear_in(irq_flag_clear_in),
  .irq_enable_out(irq_enable_out), .irq_flag_reg_out(irq_flag_reg_out), .irq_out(irq_out),
  .hit_in(hit_in), .event_out_enable_reg_out(event_out_enable_reg_out),
  .prescaler_out(prescaler_out), .wrap_event_out(wrap_event_out),
  .alarm_event_out(alarm_event_out), .tap_n_event_out(tap_n_event_out));

/* File: tb/rtcsy_core_model.sv */
// stand-in for the counter core behind the block
// assumes the bench asks for hits one cycle ahead of hit_out
`timescale 1ns/1ps
module rtcsy_core_model (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  // from the block and bench
  input  wire rtcsy_pkg::rtcsy_cmd_t cmd_in,
  input  wire logic                  tick_in,
  input  wire rtcsy_pkg::rtcsy_hit_t hit_req_in,
  // to the block
  output rtcsy_pkg::rtcsy_hit_t      hit_out,
  output logic [31:0]                count_out,
  output logic [31:0]                calendar_out
);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hit_out <= '0;
      count_out <= '0;
      calendar_out <= '0;
    end else begin
      hit_out <= hit_req_in;
      if (cmd_in.valid && cmd_in.sel == rtcsy_pkg::RTCSY_SEL_COUNT) begin
        count_out <= cmd_in.data;
      end else if (tick_in) begin
        count_out <= count_out + 32'h0000_0001;
      end
      if (cmd_in.valid && cmd_in.sel == rtcsy_pkg::RTCSY_SEL_CALENDAR) begin
        calendar_out <= cmd_in.data;
      end
    end
  end
endmodule : rtcsy_core_model

/* File: tb/rtcsy_test.sv */
// self-checking bench: irq/event model, crossing, trim and taps
// assumes the core model answers commands and forwards requested hits
`timescale 1ns/1ps
module rtcsy_test;
  logic                  clk_in, arst_n_in, slow, rv, wr, rdy, pend, rdv, tick, irq;
  logic                  en, wev, aev, cnt_on;
  logic [1:0]            mev;
  logic [3:0]            psc;
  logic [4:0]            es, ec, fc, ien, flg;
  logic [7:0]            tap, trim;
  logic [11:0]           ed, eve;
  logic [31:0]           cnt, cal, rdd, v, w;
  rtcsy_pkg::rtcsy_req_t rq;
  rtcsy_pkg::rtcsy_hit_t hreq, hit;
  rtcsy_pkg::rtcsy_cmd_t cmd;
  int bad_count, n_compared, mf, me, mv, evm, ticks, f, stl, chk, rdn;
  int taps[8];

  rtcsy_core u_rtcsy_core (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .slow_count_clock_in(slow), .req_valid_in(rv), .req_in(rq), .req_ready_out(rdy),
    .xfer_pending_bit_out(pend), .rd_valid_out(rdv), .rd_data_out(rdd),
    .irq_enable_set_reg_in(es), .irq_enable_clear_reg_in(ec), .irq_flag_clear_in(fc),
    .event_out_enable_wr_in(wr), .event_out_enable_data_in(ed), .irq_enable_out(ien),
    .irq_flag_reg_out(flg), .event_out_enable_reg_out(eve), .rate_trim_reg_out(trim),
    .enable_out(en), .prescaler_out(psc), .irq_out(irq), .hit_in(hit), .count_in(cnt),
    .calendar_in(cal), .core_cmd_out(cmd), .count_tick_out(tick),
    .wrap_event_out(wev), .match_event_out(mev), .alarm_event_out(aev),
    .tap_n_event_out(tap));
  rtcsy_core_model u_rtcsy_core_model (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .cmd_in(cmd), .tick_in(tick), .hit_req_in(hreq), .hit_out(hit), .count_out(cnt),
    .calendar_out(cal));

  initial begin
    clk_in = 0;
    forever #20 clk_in = ~clk_in;
  end
  // free-running slow clock, eight bus cycles a period
  initial begin
    slow = 0;
    #7;
    forever #160 slow = ~slow;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // raise a request and hold it until the accepting edge; fin drops it
  task automatic put(input rtcsy_pkg::rtcsy_sel_t s, input logic [31:0] d);
    rv = 1;
    rq = '{sel: s, data: d};
    stl = 0;
    for (int k = 0; k <= 400; k++) begin
      if (k == 400) begin
        bad_count++;
        print_verdict();
      end
      @(posedge clk_in);
      if (rdy) break;
      stl++;
    end
    #1;
    check({pend, rdy}, 2'b10);
  endtask : put

  // wait for the crossing to finish, then clear the done flag
  task automatic fin;
    rv = 0;
    for (int k = 0; k <= 400; k++) begin
      if (k == 400) begin
        bad_count++;
        print_verdict();
      end
      @(posedge clk_in);
      #1;
      if (!pend) break;
    end
    check({flg[4], rdy}, 2'b11);
    fc = 5'h10;
    @(posedge clk_in);
    #1;
    fc = 5'h00;
    check(flg[4], 0);
  endtask : fin

  task automatic run(input logic [7:0] t, input int len);
    put(rtcsy_pkg::RTCSY_SEL_RATE_TRIM, {24'h0, t});
    fin();
    check(trim, t);
    ticks = 0;
    foreach (taps[n]) taps[n] = 0;
    cnt_on = 1;
    repeat (len) @(posedge slow);
    @(posedge clk_in);
    #1;
    cnt_on = 0;
  endtask : run

  always @(posedge clk_in) begin
    rdn += rdv;
    if (cnt_on) begin
      ticks += tick;
      foreach (taps[n]) taps[n] += tap[n];
    end
    if (chk) begin
      mv = {hit.wrap & evm[11], hit.match & evm[9:8], hit.alarm & evm[10]};
      mf = (mf & ~fc) | {hit.alarm, hit.match, hit.wrap};
      me = (me | es) & ~ec;
      if (wr) evm = ed;
    end
  end

  always @(negedge clk_in) begin
    if (chk) begin
      check(flg, mf);
      check(ien, me);
      check(irq, |(mf[4:0] & me[4:0]));
      check({wev, mev, aev}, mv);
    end
  end

  initial begin
    arst_n_in = 0;
    {rv, wr, cnt_on, es, ec, fc, ed} = '0;
    rq = '0;
    hreq = '0;
    {bad_count, n_compared, mf, me, mv, evm, chk, rdn} = '0;
    void'($urandom(18));
    repeat (4) @(posedge clk_in);
    #1;
    arst_n_in = 1;
    check({ien, flg, eve}, 0);
    check({rdy, pend, en, psc, trim}, 32'h4000);
    chk = 1;
    // event enables are written only in cycles without hits
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_in);
      #1;
      wr = (i % 50 == 0);
      ed = $urandom;
      hreq = ((i + 1) % 50 == 0) ? '0 : $urandom;
      es = ($urandom % 4 == 0) ? $urandom : '0;
      ec = ($urandom % 6 == 0) ? $urandom : '0;
      fc = ($urandom % 5 == 0) ? $urandom : '0;
    end
    @(posedge clk_in);
    #1;
    {wr, hreq, es, ec, fc} = '0;
    @(posedge clk_in);
    #1;
    chk = 0;
    v = $urandom;
    w = $urandom;
    put(rtcsy_pkg::RTCSY_SEL_COUNT, v);
    put(rtcsy_pkg::RTCSY_SEL_CALENDAR, w);
    check(stl > 0, 1);
    fin();
    put(rtcsy_pkg::RTCSY_SEL_RD_COUNT, 0);
    fin();
    check(rdd, v);
    put(rtcsy_pkg::RTCSY_SEL_RD_CAL, 0);
    fin();
    check(rdd, w);
    check(rdn, 2);
    // prescaler above one before any trim is set
    put(rtcsy_pkg::RTCSY_SEL_CTRL, 32'h0000_0202);
    fin();
    check({en, psc}, 5'h12);
    wr = 1;
    ed = 12'hFFF;
    @(posedge clk_in);
    #1;
    wr = 0;
    run(8'h00, 2048);
    check(ticks >= 511 && ticks <= 513, 1);
    foreach (taps[n]) begin
      f = 2048 >> (n + 3);
      check(taps[n] >= f - 1 && taps[n] <= f + 1, 1);
    end
    // four trimmed periods per run, so the tick phase cannot hide the shift
    run(8'h7F, 4096);
    f = ticks;
    run(8'hFF, 4096);
    check(f > ticks, 1);
    es = 5'h1F;
    @(posedge clk_in);
    #1;
    es = 5'h00;
    put(rtcsy_pkg::RTCSY_SEL_CTRL, 32'h0000_0001);
    fin();
    check({ien, eve, trim, en, psc}, 0);
    check(flg, 0);
    print_verdict();
  end
endmodule : rtcsy_test
